// ==== logic/asr_regs.svh ====
`ifndef ASR_REGS_SVH
`define ASR_REGS_SVH

// channel count and sample width
`define ASR_CHANNELS        8
`define ASR_WORD_BITS       24
// master clocks per conversion period
`define ASR_CONV_CLKS       32'h0000_0100
// conversions of filter settling after realign is released
`define ASR_SYNC_SETTLE     8'h80
// conversions of settling after a channel leaves power-down
`define ASR_PWR_SETTLE      8'h81
// master clocks of low sleep input before a channel powers down
`define ASR_SLEEP_MIN_CLKS  2'h2
// master clocks of low realign input that form a valid pulse
`define ASR_SYNC_MIN_CLKS   2'h1

`endif

// ==== logic/asr_pkg.sv ====
package asr_pkg;

   typedef enum logic [2:0]
   {
      fmt_spi_dyn   = 3'b000,
      fmt_spi_fix   = 3'b001,
      fmt_spi_disc  = 3'b010,
      fmt_fs_dyn    = 3'b011,
      fmt_fs_fix    = 3'b100,
      fmt_fs_disc   = 3'b101,
      fmt_modulator = 3'b110,
      fmt_invalid   = 3'b111
   } asr_fmt_t;

   typedef enum logic [1:0]
   {
      st_idle  = 2'b00,
      st_held  = 2'b01,
      st_shift = 2'b10,
      st_gap   = 2'b11
   } asr_state_t;

endpackage

// ==== logic/asr_readout.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "asr_regs.svh"

// Behaviour
// [R1] realign low halts conversion and clears filter counters of all channels
// [R2] realign high restarts every channel together on the shared master clock
// [R3] host holds realign low at least one master clock
// [R4] spi: ready_n high while realign low and settling, low when data valid
// [R5] frame-sync: outputs low while realign low and settling, then valid data
// [R6] frame-sync: host keeps strobe and clocks running, realigns after interruption
// [R7] host should realign once after power-on when data first appear
// [R8] sleep low two master clocks powers a channel down, high wakes it
// [R9] woken channel data valid within 130 (spi) or 129 (frame-sync) conversions
// [R10] all channels asleep: biasing off, outputs still driven
// [R11] waking or sleeping a channel leaves running channels untouched
// [R12] woken channels rejoin the shared conversion timing without realign
// [R13] tdm fixed zeros a sleeping slot, tdm dynamic packs higher channels down
// [R14] discrete mode outputs zeros for a sleeping channel
// [R15] dynamic tdm adds a woken channel only once its data are ready
// [R16] three-bit format select chooses protocol, output mode and position
// [R17] spi read-only: falling ready_n, then msb first on falling sclk
// [R18] host uses spi only with master clock up to 27 MHz
// [R19] chain input sampled on each falling serial clock edge; code samples it in tdm formats only
// [R20] host captures serial data on rising serial clock edge
// [R21] host may run sclk up to master clock, free or stopped; code samples sclk on master clock, so needs it at half that or less
// [R22] host waits one master clock after ready_n falls before rising sclk
// [R23] ready_n rises on first falling sclk, pulses high before unread reload
// [R24] format code 111 is invalid and holds serial outputs low
module asr_readout
#(
   parameter int CHANNELS  = `ASR_CHANNELS,
   parameter int WORD_BITS = `ASR_WORD_BITS,
   parameter int CONV_CLKS = `ASR_CONV_CLKS
)
(
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   input  wire logic                          realign_n,
   input  wire logic [CHANNELS-1:0]           chan_sleep_n,
   input  wire logic [2:0]                    fmt_sel,
   input  wire logic                          sclk,
   input  wire logic                          frame_strobe,
   input  wire logic                          chain_in,
   input  wire logic [CHANNELS*WORD_BITS-1:0] conv_data,
   input  wire logic                          conv_valid,
   output logic                               conv_ready,
   output logic                               conv_tick,
   output logic                               ready_n,
   output logic [CHANNELS-1:0]                dout,
   output logic [CHANNELS-1:0]                chan_live,
   output logic                               bias_off
);

   localparam int FW  = CHANNELS * WORD_BITS;
   localparam int CW  = $clog2(CONV_CLKS);
   localparam int SYW = CHANNELS + 7;
   // idle pin levels, so leaving reset fakes neither a realign nor a power-down
   localparam logic [SYW-1:0] SY_IDLE = {1'b1, {CHANNELS{1'b1}}, 6'h00};

   // two-stage synchronisers for every pin input
   logic [SYW-1:0]             sync_m;
   logic [SYW-1:0]             sync_s;
   logic                       sclk_d;
   logic                       fs_d;
   logic                       rl_s;
   logic [CHANNELS-1:0]        sleep_s;
   logic [2:0]                 fmt_s;
   logic                       sclk_s;
   logic                       fs_s;
   logic                       chain_s;
   logic                       sclk_fall;
   logic                       fs_rise;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_m <= SY_IDLE;
         sync_s <= SY_IDLE;
         sclk_d <= 1'b0;
         fs_d   <= 1'b0;
      end
      else
      begin
         sync_m <= {realign_n, chan_sleep_n, fmt_sel, sclk, frame_strobe, chain_in};
         sync_s <= sync_m;
         sclk_d <= sclk_s;
         fs_d   <= fs_s;
      end
   end

   assign {rl_s, sleep_s, fmt_s, sclk_s, fs_s, chain_s} = sync_s;
   assign sclk_fall = sclk_d & ~sclk_s;
   assign fs_rise   = fs_s & ~fs_d;

   // format decode
   asr_pkg::asr_fmt_t fmt;
   logic              is_spi;
   logic              is_fs;
   logic              is_tdm;
   logic              is_dyn;

   assign fmt    = asr_pkg::asr_fmt_t'(fmt_s);
   assign is_spi = (fmt == asr_pkg::fmt_spi_dyn) | (fmt == asr_pkg::fmt_spi_fix)
                 | (fmt == asr_pkg::fmt_spi_disc);                     // see [R16]
   assign is_fs  = (fmt == asr_pkg::fmt_fs_dyn) | (fmt == asr_pkg::fmt_fs_fix)
                 | (fmt == asr_pkg::fmt_fs_disc);                      // see [R16]
   assign is_tdm = (fmt != asr_pkg::fmt_spi_disc) & (fmt != asr_pkg::fmt_fs_disc);
   assign is_dyn = (fmt == asr_pkg::fmt_spi_dyn) | (fmt == asr_pkg::fmt_fs_dyn);

   // shared conversion timing, held at zero while realign is low
   logic [CW-1:0] conv_cnt;
   logic [7:0]    sync_cnt;
   logic          sync_done;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         conv_cnt  <= '0;
         conv_tick <= 1'b0;
         sync_cnt  <= '0;
      end
      else if (!rl_s)
      begin
         conv_cnt  <= '0;                                              // see [R1]
         conv_tick <= 1'b0;
         sync_cnt  <= '0;                                              // see [R1]
      end
      else
      begin
         conv_cnt  <= CW'(conv_cnt + 1'b1);                            // see [R2]
         conv_tick <= (conv_cnt == CW'(CONV_CLKS - 1));
         if (conv_tick && !sync_done)
         begin
            sync_cnt <= sync_cnt + 8'h01;
         end
      end
   end

   assign sync_done = (sync_cnt == `ASR_SYNC_SETTLE);                  // see [R4] [R5]

   // per-channel power-down filter and wake-up settling
   logic [1:0]          slp_cnt [CHANNELS];
   logic [7:0]          pwr_cnt [CHANNELS];
   logic [CHANNELS-1:0] asleep;
   logic [CHANNELS-1:0] ok;
   logic [CHANNELS-1:0] next_dout;
   logic                all_asleep;
   logic [FW-1:0]       next_sr;

   generate
      for (genvar g = 0; g < CHANNELS; g++)
      begin : g_ch
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               slp_cnt[g] <= '0;
               pwr_cnt[g] <= '0;
            end
            else
            begin
               if (sleep_s[g])
               begin
                  slp_cnt[g] <= 2'h0;
               end
               else if (!asleep[g])
               begin
                  slp_cnt[g] <= slp_cnt[g] + 2'h1;                     // see [R8]
               end
               if (asleep[g])
               begin
                  pwr_cnt[g] <= 8'h00;
               end
               else if (conv_tick && pwr_cnt[g] != `ASR_PWR_SETTLE)
               begin
                  pwr_cnt[g] <= pwr_cnt[g] + 8'h01;                    // see [R9] [R12]
               end
            end
         end

         assign asleep[g] = (slp_cnt[g] == `ASR_SLEEP_MIN_CLKS);       // see [R8]
         assign ok[g]     = ~asleep[g] & sync_done
                          & (pwr_cnt[g] == `ASR_PWR_SETTLE);           // see [R9] [R11]
         if (g == 0)
         begin : g_first
            assign next_dout[g] = next_sr[FW-1];
         end
         else
         begin : g_rest
            assign next_dout[g] = ~is_tdm & next_sr[FW-1-WORD_BITS*g]; // see [R14]
         end
      end
   endgenerate

   assign all_asleep = &asleep;                                        // see [R10]

   // frame composition
   function automatic logic [FW-1:0] pack_live(input logic [FW-1:0]       d,
                                               input logic [CHANNELS-1:0] live);
      logic [FW-1:0] r;
      int            k;
      r = '0;
      k = 0;
      for (int i = 0; i < CHANNELS; i++)
      begin
         if (live[i])
         begin
            r[FW-1-WORD_BITS*k -: WORD_BITS] = d[FW-1-WORD_BITS*i -: WORD_BITS];
            k++;
         end
      end
      return r;
   endfunction

   function automatic logic [FW-1:0] zero_dead(input logic [FW-1:0]       d,
                                               input logic [CHANNELS-1:0] live);
      logic [FW-1:0] r;
      r = d;
      for (int i = 0; i < CHANNELS; i++)
      begin
         if (!live[i])
         begin
            r[FW-1-WORD_BITS*i -: WORD_BITS] = '0;
         end
      end
      return r;
   endfunction

   function automatic logic [FW-1:0] lane_lsbs();
      logic [FW-1:0] r;
      r = '0;
      for (int i = 0; i < CHANNELS; i++)
      begin
         r[WORD_BITS*i] = 1'b1;
      end
      return r;
   endfunction

   // two-entry frame buffer between the filter and the shifter
   logic [FW-1:0] fifo_mem [2];
   logic          wr_ptr;
   logic          rd_ptr;
   logic [1:0]    fifo_cnt;
   logic [1:0]    next_cnt;
   logic          push;
   logic          pop;
   logic          fifo_valid;

   assign push       = conv_valid & conv_ready;
   assign fifo_valid = (fifo_cnt != 2'h0);
   assign next_cnt   = !rl_s ? 2'h0 : 2'(fifo_cnt + {1'b0, push} - {1'b0, pop});

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         fifo_mem[wr_ptr] <= conv_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr     <= 1'b0;
         rd_ptr     <= 1'b0;
         fifo_cnt   <= 2'h0;
         conv_ready <= 1'b0;
      end
      else
      begin
         wr_ptr     <= !rl_s ? 1'b0 : wr_ptr ^ push;                   // see [R1]
         rd_ptr     <= !rl_s ? 1'b0 : rd_ptr ^ pop;
         fifo_cnt   <= next_cnt;
         conv_ready <= (next_cnt != 2'h2);
      end
   end

   // readout control
   logic                   blank;
   logic                   load_spi;
   logic                   load_fs;
   logic                   shift_en;
   logic [FW-1:0]          sr;
   logic [FW-1:0]          composed;
   logic [FW-1:0]          shifted;
   asr_pkg::asr_state_t    state;
   asr_pkg::asr_state_t    next_state;

   assign blank    = ~rl_s | ~sync_done | ~(is_spi | is_fs) | all_asleep; // see [R4] [R5] [R24]
   assign load_spi = is_spi & ~blank & fifo_valid & (state != asr_pkg::st_held); // see [R17]
   assign load_fs  = is_fs & ~blank & fifo_valid & fs_rise;
   assign pop      = load_spi | load_fs;
   assign shift_en = ~blank & sclk_fall
                   & (is_fs | state == asr_pkg::st_held | state == asr_pkg::st_shift);
   assign composed = (is_tdm & is_dyn) ? pack_live(fifo_mem[rd_ptr], ok)  // see [R13] [R15]
                                       : zero_dead(fifo_mem[rd_ptr], ok); // see [R13] [R14]
   assign shifted  = is_tdm ? {sr[FW-2:0], chain_s}                      // see [R19]
                            : (sr << 1) & ~lane_lsbs();                  // see [R14]
   assign next_sr  = blank    ? '0
                   : pop      ? composed
                   : shift_en ? shifted                                  // see [R17]
                   : sr;

   always_comb
   begin
      next_state = state;
      case (state)
         asr_pkg::st_idle:
         begin
            if (load_spi)
            begin
               next_state = asr_pkg::st_held;
            end
         end
         asr_pkg::st_held:
         begin
            if (fifo_valid)
            begin
               next_state = asr_pkg::st_gap;                             // see [R23]
            end
            else if (sclk_fall)
            begin
               next_state = asr_pkg::st_shift;                           // see [R23]
            end
         end
         asr_pkg::st_shift, asr_pkg::st_gap:
         begin
            if (load_spi)
            begin
               next_state = asr_pkg::st_held;
            end
         end
         default:
         begin
            next_state = asr_pkg::st_idle;
         end
      endcase
      if (blank)
      begin
         next_state = asr_pkg::st_idle;                                  // see [R4]
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state     <= asr_pkg::st_idle;
         sr        <= '0;
         ready_n   <= 1'b1;
         dout      <= '0;
         chan_live <= '0;
         bias_off  <= 1'b0;
      end
      else
      begin
         state     <= next_state;
         sr        <= next_sr;
         ready_n   <= (next_state != asr_pkg::st_held);                  // see [R4] [R23]
         dout      <= next_dout;
         chan_live <= ok;
         bias_off  <= all_asleep;                                        // see [R10]
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_realign_low;
      !rl_s [*2];
   endsequence

   sequence s_sleep_two;
      !sleep_s[0] [*2];
   endsequence

   property p_realign_halt;
      !rl_s |=> (conv_cnt == '0) && (sync_cnt == 8'h00) && (fifo_cnt == 2'h0);
   endproperty
   a_realign_halt: assert property (p_realign_halt) // see [R1]
      else $error("realign low did not clear conversion state");

   property p_realign_restart;
      !rl_s ##1 rl_s |=> (conv_cnt == CW'(1)) ##1 (conv_cnt == CW'(2));
   endproperty
   a_realign_restart: assert property (p_realign_restart) // see [R2]
      else $error("conversion did not restart after realign");

   property p_realign_outputs;
      s_realign_low |-> ready_n && (dout == '0);
   endproperty
   a_realign_outputs: assert property (p_realign_outputs) // see [R4] [R5]
      else $error("outputs not idle during realign");

   property p_settle_quiet;
      !sync_done |=> (dout == '0) && ready_n;
   endproperty
   a_settle_quiet: assert property (p_settle_quiet) // see [R5]
      else $error("data shown while filter settling");

   property p_sleep_enter;
      s_sleep_two |=> asleep[0] && !ok[0];
   endproperty
   a_sleep_enter: assert property (p_sleep_enter) // see [R8]
      else $error("channel did not power down after two clocks");

   property p_bias;
      all_asleep |=> bias_off && (dout == '0);
   endproperty
   a_bias: assert property (p_bias) // see [R10]
      else $error("micropower state not shown");

   property p_dead_lane;
      pop && !(is_tdm && is_dyn) && !ok[2] |=> (sr[FW-1-2*WORD_BITS -: WORD_BITS] == '0);
   endproperty
   a_dead_lane: assert property (p_dead_lane) // see [R13] [R14]
      else $error("sleeping channel lane not zero");

   property p_spi_load;
      load_spi |=> !ready_n && (sr == $past(composed)) && (dout[0] == sr[FW-1]);
   endproperty
   a_spi_load: assert property (p_spi_load) // see [R17]
      else $error("spi load did not present msb with ready low");

   property p_ready_release;
      (state == asr_pkg::st_held) && sclk_fall |=> ready_n;
   endproperty
   a_ready_release: assert property (p_ready_release) // see [R23]
      else $error("ready_n did not rise on first falling sclk");

   property p_bad_format;
      (fmt_s == 3'h7) |=> (dout == '0) && ready_n;
   endproperty
   a_bad_format: assert property (p_bad_format) // see [R24]
      else $error("invalid format drove serial outputs");

endmodule

`default_nettype wire

// ==== verification/asr_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module asr_host_model
(
   input  wire logic       clk,
   input  wire logic       ready_n,
   input  wire logic [7:0] dout,
   output logic            sclk,
   output logic            frame_strobe,
   output logic [199:0]    word,
   output logic            got,
   output logic            rose
);
   initial
   begin
      sclk = 1'b0;
      frame_strobe = 1'b0;
      word = '0;
      got = 1'b0;
      rose = 1'b0;
   end

   // serial clock of 8 master clocks, held low between frames
   task automatic read_frame(input bit fs, input bit disc);
      logic [199:0] acc;
      int           w;
      acc = '0;
      w = 0;
      rose <= 1'b0;
      if (fs)
      begin
         frame_strobe <= 1'b1;
         repeat (6) @(posedge clk);
      end
      else
      begin
         while (ready_n !== 1'b0 && w < 5000)
         begin
            @(posedge clk);
            w++;
         end
         repeat (2) @(posedge clk);
      end
      for (int b = 0; b < (disc ? 24 : 200); b++)
      begin
         sclk <= 1'b1;
         for (int l = 0; l < 8; l++)
            if (disc || l == 0)
               acc[199 - 24 * l - b] = dout[l];
         repeat (4) @(posedge clk);
         sclk <= 1'b0;
         frame_strobe <= 1'b0;
         repeat (4) @(posedge clk);
         if (b == 1 && ready_n === 1'b1)
            rose <= 1'b1;
      end
      word <= acc;
      got <= 1'b1;
      @(posedge clk);
      got <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== verification/test_adc_sync_powerdown_serial_readout.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_adc_sync_powerdown_serial_readout;
   logic         clk;
   logic         rst_n;
   logic         realign_n;
   logic [7:0]   chan_sleep_n;
   logic [2:0]   fmt_sel;
   logic         chain_in;
   logic [191:0] conv_data;
   logic         conv_valid;
   logic         conv_ready;
   logic         conv_tick;
   logic         ready_n;
   logic [7:0]   dout;
   logic [7:0]   chan_live;
   logic         bias_off;
   logic         sclk;
   logic         frame_strobe;
   logic [199:0] word;
   logic         got;
   logic         rose;
   logic [7:0]   awake;
   logic [199:0] exp_q[$];
   int           error_cnt;
   int           checked;
   int           ticks;
   int           cycles;
   int           t0;
   int           t_live;

   asr_readout #(.CONV_CLKS(8)) DUT (.clk(clk), .rst_n(rst_n), .realign_n(realign_n),
      .chan_sleep_n(chan_sleep_n), .fmt_sel(fmt_sel), .sclk(sclk),
      .frame_strobe(frame_strobe), .chain_in(chain_in), .conv_data(conv_data),
      .conv_valid(conv_valid), .conv_ready(conv_ready), .conv_tick(conv_tick),
      .ready_n(ready_n), .dout(dout), .chan_live(chan_live), .bias_off(bias_off));

   asr_host_model host (.clk(clk), .ready_n(ready_n), .dout(dout), .sclk(sclk),
      .frame_strobe(frame_strobe), .word(word), .got(got), .rose(rose));

   always #12.5 clk = ~clk; // spi timing here is counted in clocks only

   task automatic check(input string nm, input logic [199:0] seen, input logic [199:0] exp);
      checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (conv_tick === 1'b1)
         ticks++;
      if (cycles == 60000)
      begin
         error_cnt++;
         complete_run();
      end
   end

   always @(posedge chan_live[2])
      t_live = ticks;

   always @(posedge got)
      if (exp_q.size() == 0)
         check("unexpected frame", 1'b1, 1'b0);
      else
         check("frame", word, exp_q.pop_front());

   // serial image of a frame as the host should see it, chain bits at the tail in tdm formats, zeros there in discrete
   function automatic logic [199:0] expect_of(logic [191:0] d, logic [2:0] f);
      logic [199:0] e;
      int           p;
      e = (f == 3'b010 || f == 3'b101) ? '0 : {200{chain_in}};
      p = 199;
      for (int c = 0; c < 8; c++)
         if (f == 3'b000 || f == 3'b011)
         begin
            if (awake[c])
            begin
               e[p -: 24] = d[191 - 24 * c -: 24];
               p -= 24;
            end
         end
         else
            e[199 - 24 * c -: 24] = awake[c] ? d[191 - 24 * c -: 24] : 24'h000000;
      return e;
   endfunction

   task automatic push(input logic [2:0] f, input bit note);
      logic [191:0] d;
      int           w;
      d = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
      w = 0;
      if (note)
         exp_q.push_back(expect_of(d, f));
      @(posedge clk);
      conv_data <= d;
      conv_valid <= 1'b1;
      @(posedge clk);
      while (conv_ready !== 1'b1 && w < 100)
      begin
         @(posedge clk);
         w++;
      end
      conv_valid <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] f);
      host.read_frame(f >= 3'b011, f == 3'b010 || f == 3'b101);
      if (f < 3'b011)
         check("ready_n release", rose, 1'b1);
   endtask

   task automatic use_fmt(input logic [2:0] f);
      fmt_sel <= f;
      repeat (4) @(posedge clk);
   endtask

   task automatic wait_low(input int lim);
      int w;
      w = 0;
      while (ready_n !== 1'b0 && w < lim)
      begin
         @(posedge clk);
         w++;
      end
   endtask

   task automatic settle(input int lim);
      int w;
      w = 0;
      while (chan_live !== awake && w < lim)
      begin
         @(posedge clk);
         w++;
      end
      check("live set", chan_live, awake);
   endtask

   initial
   begin
      void'($urandom(60));
      clk = 1'b0;
      rst_n = 1'b0;
      realign_n = 1'b1;
      chan_sleep_n = 8'hff;
      fmt_sel = 3'b001;
      chain_in = 1'b1;
      conv_data = '0;
      conv_valid = 1'b0;
      awake = 8'hff;
      repeat (12) @(posedge clk);
      check("reset outputs", {ready_n, dout, conv_ready, conv_tick, chan_live, bias_off},
         {1'b1, 8'h00, 1'b0, 1'b0, 8'h00, 1'b0});
      rst_n <= 1'b1;
      $display("test reset done");
      settle(3000);
      for (int f = 0; f < 3; f++)
      begin
         use_fmt(3'(f));
         push(3'(f), 1'b1);
         rd(3'(f));
      end
      $display("test spi formats done");
      chain_in <= 1'b0;
      chan_sleep_n <= 8'hfb;
      awake = 8'hfb;
      settle(20);
      for (int f = 0; f < 6; f++)
      begin
         use_fmt(3'(f));
         push(3'(f), 1'b1);
         rd(3'(f));
      end
      $display("test sleeping channel done");
      use_fmt(3'b000);
      chan_sleep_n <= 8'hff;
      t0 = ticks;
      push(3'b000, 1'b1);
      rd(3'b000);
      check("wake ticks", (t_live - t0) inside {[127:130]}, 1'b1);
      awake = 8'hff;
      push(3'b000, 1'b1);
      rd(3'b000);
      $display("test wake done");
      chan_sleep_n <= 8'h00;
      awake = 8'h00;
      repeat (10) @(posedge clk);
      check("micropower", {bias_off, chan_live, dout, ready_n}, {1'b1, 8'h00, 8'h00, 1'b1});
      chan_sleep_n <= 8'hff;
      awake = 8'hff;
      settle(3000);
      check("bias on", bias_off, 1'b0);
      $display("test all asleep done");
      use_fmt(3'b111);
      push(3'b100, 1'b1);
      push(3'b100, 1'b1);
      repeat (3) @(posedge clk);
      check("buffer full", conv_ready, 1'b0);
      check("invalid format", {ready_n, dout}, {1'b1, 8'h00});
      use_fmt(3'b110);
      check("modulator format", {ready_n, dout}, {1'b1, 8'h00});
      use_fmt(3'b100);
      rd(3'b100);
      rd(3'b100);
      check("buffer drained", conv_ready, 1'b1);
      $display("test buffer done");
      use_fmt(3'b001);
      push(3'b001, 1'b0);
      wait_low(3000);
      realign_n <= 1'b0;
      repeat (2) @(posedge clk);
      realign_n <= 1'b1;
      t0 = ticks;
      repeat (4) @(posedge clk);
      check("realign blank", {ready_n, dout}, {1'b1, 8'h00});
      push(3'b001, 1'b1);
      wait_low(3000);
      check("settle ticks", (ticks - t0) inside {[127:129]}, 1'b1);
      rd(3'b001);
      $display("test realign done");
      check("frames left", exp_q.size(), 0);
      complete_run();
   end
endmodule
`default_nettype wire
